// >>> cpu_sideband_nmi_control.sv
// Purpose: Drives NMI, SMI, clock-stop and sleep lines to the processor
// Assumes: Single clock mclk_i; synchronous active-low reset rstn_i
// Notes: Open-drain pins appear as out/enable pairs; NMI is push-pull
//
// Summary of operation
// - NMI rises on system error or channel check if that source is permitted.
// - Per-source NMI status bits stay set until software clears them.
// - Setting a source disable bit clears that source's request; NMI drops unless the other source is pending.
// - NMI enabled only when a source's disable bit and the global mask are zero.
// - NMI low in reset, low after reset until an event, low in suspend.
// - Open-drain sleep request output puts the processor to sleep.
// - Active-low SMI asserted synchronously on enabled hardware or software events.
// - Active-low clock-stop request changes only on the clock edge.
//
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
module cpu_sideband_nmi_control
  import sideband_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic serr_n_i,
  input wire logic chan_chk_n_i,
  input wire logic smi_hw_event_i,
  input wire logic stop_hw_event_i,
  input wire logic suspend_i,
  output logic nmi_o,
  output logic cpu_sleep_request_o,
  output logic cpu_sleep_request_oe_o,
  output logic system_mgmt_interrupt_req_o,
  output logic system_mgmt_interrupt_req_oe_o,
  output logic cpu_clock_stop_request_o,
  output logic cpu_clock_stop_request_oe_o,
  output logic irq_o,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [4:0] hw_sync1_r;
  logic [4:0] hw_sync2_r;
  logic serr_lvl;
  logic chk_lvl;
  logic susp_lvl;
  logic smi_hw;
  logic stop_hw;
  logic serr_dis_r;
  logic chk_dis_r;
  logic serr_sts_r;
  logic chk_sts_r;
  logic nmi_mask_r;
  logic [4:0] pwr_r;
  logic [EV_W-1:0] ev_sts_r;
  logic [EV_W-1:0] ev_mask_r;
  logic [EV_W-1:0] ev_set;
  logic smi_act;
  logic stop_act;
  logic nmi_nxt;
  logic smi_prev_r;
  logic stop_prev_r;
  logic nmi_prev_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_have_r;
  logic w_have_r;
  logic wr_go;
  logic rd_go;
  logic sts_clr;
  logic chk_clr;
  logic irq_rd_clr;

  // Two-flop synchronisers for pin inputs
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      sync1_r <= 3'h7;
      sync2_r <= 3'h7;
      hw_sync1_r <= 5'h00;
      hw_sync2_r <= 5'h00;
    end else begin
      sync1_r <= {serr_n_i, chan_chk_n_i, 1'b1};
      sync2_r <= sync1_r;
      hw_sync1_r <= {smi_hw_event_i, stop_hw_event_i, suspend_i, 2'b00};
      hw_sync2_r <= hw_sync1_r;
    end
  end

  assign serr_lvl = ~sync2_r[2];
  assign chk_lvl = ~sync2_r[1];
  assign smi_hw = hw_sync2_r[4];
  assign stop_hw = hw_sync2_r[3];
  assign susp_lvl = hw_sync2_r[2];

  // AXI write channel capture, address and data in either order
  assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_have_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (awaddr_r)
          NMI_CTRL_OFS, NMI_MASK_OFS, PWR_CTRL_OFS, IRQ_STAT_OFS, IRQ_MASK_OFS: s_axi_bresp <= RESP_OKAY;
          default: s_axi_bresp <= RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Software clear strobes: writing 1 to a status bit clears it
  assign sts_clr = wr_go && awaddr_r == NMI_CTRL_OFS && wstrb_r[0] && wdata_r[SERR_STS_BIT];
  assign chk_clr = wr_go && awaddr_r == NMI_CTRL_OFS && wstrb_r[0] && wdata_r[CHK_STS_BIT];

  // Control registers: source disables, global mask, power control and interrupt mask
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      serr_dis_r <= NMI_CTRL_RST[SERR_DIS_BIT];
      chk_dis_r <= NMI_CTRL_RST[CHK_DIS_BIT];
      nmi_mask_r <= NMI_MASK_RST[NMI_MASK_BIT];
      pwr_r <= PWR_CTRL_RST;
      ev_mask_r <= IRQ_MASK_RST;
    end else if (wr_go && wstrb_r[0]) begin
      case (awaddr_r)
        NMI_CTRL_OFS: begin
          serr_dis_r <= wdata_r[SERR_DIS_BIT];
          chk_dis_r <= wdata_r[CHK_DIS_BIT];
        end
        NMI_MASK_OFS: nmi_mask_r <= wdata_r[NMI_MASK_BIT];
        PWR_CTRL_OFS: pwr_r <= wdata_r[4:0];
        IRQ_MASK_OFS: ev_mask_r <= wdata_r[EV_W-1:0];
        default: ;
      endcase
    end
  end

  // Per-source status, sticky until cleared; a new event wins over the clear
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      serr_sts_r <= 1'b0;
      chk_sts_r <= 1'b0;
    end else begin
      if (serr_lvl && !serr_dis_r) serr_sts_r <= 1'b1;
      else if (serr_dis_r || sts_clr) serr_sts_r <= 1'b0;
      if (chk_lvl && !chk_dis_r) chk_sts_r <= 1'b1;
      else if (chk_dis_r || chk_clr) chk_sts_r <= 1'b0;
    end
  end

  // NMI level; processor takes the rising edge, so it is held until serviced
  assign nmi_nxt = !susp_lvl && !nmi_mask_r && (serr_sts_r || chk_sts_r);

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) nmi_o <= 1'b0;
    else nmi_o <= nmi_nxt;
  end

  // SMI and clock-stop requests from enabled hardware or software sources
  assign smi_act = (pwr_r[SMI_EN_BIT] && smi_hw) || pwr_r[SMI_SW_BIT];
  assign stop_act = (pwr_r[STOP_EN_BIT] && stop_hw) || pwr_r[STOP_SW_BIT];

  // Open-drain drivers: output low only while enabled, otherwise floating
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      cpu_sleep_request_o <= 1'b0;
      cpu_sleep_request_oe_o <= 1'b0;
      system_mgmt_interrupt_req_o <= 1'b0;
      system_mgmt_interrupt_req_oe_o <= 1'b0;
      cpu_clock_stop_request_o <= 1'b0;
      cpu_clock_stop_request_oe_o <= 1'b0;
    end else begin
      cpu_sleep_request_oe_o <= pwr_r[SLEEP_BIT] && !susp_lvl;
      system_mgmt_interrupt_req_oe_o <= smi_act && !susp_lvl;
      cpu_clock_stop_request_oe_o <= stop_act && !susp_lvl;
    end
  end

  // Interrupt events: rising edges of the request lines
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      smi_prev_r <= 1'b0;
      stop_prev_r <= 1'b0;
      nmi_prev_r <= 1'b0;
    end else begin
      smi_prev_r <= smi_act;
      stop_prev_r <= stop_act;
      nmi_prev_r <= nmi_nxt;
    end
  end

  assign ev_set = {stop_act && !stop_prev_r, smi_act && !smi_prev_r, nmi_nxt && !nmi_prev_r,
                   chk_lvl && !chk_dis_r && !chk_sts_r, serr_lvl && !serr_dis_r && !serr_sts_r};
  assign irq_rd_clr = rd_go && s_axi_araddr == IRQ_STAT_OFS;

  // Sticky event bits, cleared on read; set wins over the read clear
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      ev_sts_r <= '0;
      irq_o <= 1'b0;
    end else begin
      ev_sts_r <= (irq_rd_clr ? '0 : ev_sts_r) | ev_set;
      irq_o <= |(((irq_rd_clr ? '0 : ev_sts_r) | ev_set) & ev_mask_r);
    end
  end

  // AXI read channel, one cycle to answer
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        case (s_axi_araddr)
          NMI_CTRL_OFS: s_axi_rdata <= {24'h00_0000, serr_sts_r, chk_sts_r, 2'b00, chk_dis_r, serr_dis_r, 2'b00};
          NMI_MASK_OFS: s_axi_rdata <= {24'h00_0000, nmi_mask_r, 6'h00, nmi_o};
          PWR_CTRL_OFS: s_axi_rdata <= {27'h000_0000, pwr_r};
          IRQ_STAT_OFS: s_axi_rdata <= {27'h000_0000, ev_sts_r};
          IRQ_MASK_OFS: s_axi_rdata <= {27'h000_0000, ev_mask_r};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// >>> sideband_pkg.sv
// Purpose: Constants for the processor sideband interrupt and power control block
// Assumes: AXI4-Lite register access, 32-bit data, 125 MHz clock
// Notes: Offsets are byte addresses of aligned words
package sideband_pkg;
  localparam int ADDR_W = 8;
  // Register byte offsets
  localparam logic [7:0] NMI_CTRL_OFS = 8'h00;   // Source enables/disables and status
  localparam logic [7:0] NMI_MASK_OFS = 8'h04;   // Global mask and NMI output state
  localparam logic [7:0] PWR_CTRL_OFS = 8'h08;   // Sleep, SMI and clock-stop requests
  localparam logic [7:0] IRQ_STAT_OFS = 8'h0C;   // Sticky events, cleared on read
  localparam logic [7:0] IRQ_MASK_OFS = 8'h10;   // Interrupt mask
  // NMI control fields
  localparam int SERR_DIS_BIT = 2;
  localparam int CHK_DIS_BIT = 3;
  localparam int SERR_STS_BIT = 7;
  localparam int CHK_STS_BIT = 6;
  localparam int NMI_MASK_BIT = 7;
  // Power control fields
  localparam int SLEEP_BIT = 0;
  localparam int SMI_SW_BIT = 1;
  localparam int STOP_SW_BIT = 2;
  localparam int SMI_EN_BIT = 3;
  localparam int STOP_EN_BIT = 4;
  // Interrupt event bits
  localparam int EV_SERR = 0;
  localparam int EV_CHK = 1;
  localparam int EV_NMI = 2;
  localparam int EV_SMI = 3;
  localparam int EV_STOP = 4;
  localparam int EV_W = 5;
  // Reset values
  localparam logic [7:0] NMI_CTRL_RST = 8'h0C;
  localparam logic [7:0] NMI_MASK_RST = 8'h80;
  localparam logic [4:0] PWR_CTRL_RST = 5'h00;
  localparam logic [4:0] IRQ_MASK_RST = 5'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> cpu_sideband_nmi_control_sva.sv
// Purpose: Port checks for the sideband block
// Assumes: One clock, sync active-low reset
// Notes: Bound to every instance
`timescale 1ns/1ps
module cpu_sideband_nmi_control_sva (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic suspend_i,
  input wire logic nmi_o,
  input wire logic cpu_sleep_request_o,
  input wire logic cpu_sleep_request_oe_o,
  input wire logic system_mgmt_interrupt_req_o,
  input wire logic system_mgmt_interrupt_req_oe_o,
  input wire logic cpu_clock_stop_request_o,
  input wire logic cpu_clock_stop_request_oe_o,
  input wire logic irq_o,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  a_reset_quiet: assert property (disable iff (1'b0) !rstn_i |=> !(nmi_o || irq_o ||
    cpu_sleep_request_oe_o || system_mgmt_interrupt_req_oe_o || cpu_clock_stop_request_oe_o))
    else $error("output active after reset");
  a_susp_nmi_low: assert property (suspend_i [*4] |-> !nmi_o) else $error("nmi high in suspend");
  a_susp_float: assert property (suspend_i [*4] |-> !(cpu_sleep_request_oe_o ||
    system_mgmt_interrupt_req_oe_o || cpu_clock_stop_request_oe_o)) else $error("pin driven in suspend");
  a_od_only_low: assert property (!(cpu_sleep_request_o || system_mgmt_interrupt_req_o ||
    cpu_clock_stop_request_o)) else $error("open-drain pin driven high");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
endmodule
bind cpu_sideband_nmi_control cpu_sideband_nmi_control_sva i_cpu_sideband_nmi_control_sva (.*);

// >>> cpu_host_model.sv
// Purpose: Processor side of the sideband pins
// Assumes: Open-drain request pin pulled up on the board
// Notes: Counts the requests the processor would take
`timescale 1ns/1ps
module cpu_host_model (
  input wire logic clk_i,
  input wire logic nmi_i,
  input wire logic smi_oe_i,
  output int nmi_cnt_o,
  output int smi_cnt_o
);
  logic nmi_q = 1'b0;
  logic smi_n_q = 1'b1;
  wire logic smi_n = !smi_oe_i; // Pull-up when released
  initial nmi_cnt_o = 0;
  initial smi_cnt_o = 0;
  // Requests are taken on edges only, never on levels
  always @(posedge clk_i) begin
    nmi_q <= nmi_i;
    smi_n_q <= smi_n;
    if (nmi_i && !nmi_q) nmi_cnt_o <= nmi_cnt_o + 1;
    if (!smi_n && smi_n_q) smi_cnt_o <= smi_cnt_o + 1;
  end
endmodule

// >>> cpu_sideband_nmi_control_tb.sv
// Purpose: Self-checking bench for the sideband block
// Assumes: Register access over AXI4-Lite
// Notes: Pin waits cover the two-flop input sync
`timescale 1ns/1ps
module cpu_sideband_nmi_control_tb;
  import sideband_pkg::*;
  logic mclk_i = 0, rstn_i = 0, serr_n_i = 1, chan_chk_n_i = 1;
  logic smi_hw_event_i = 0, stop_hw_event_i = 0, suspend_i = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, nmi_o, irq_o;
  logic cpu_sleep_request_o, cpu_sleep_request_oe_o, system_mgmt_interrupt_req_o;
  logic system_mgmt_interrupt_req_oe_o, cpu_clock_stop_request_o, cpu_clock_stop_request_oe_o;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int failures = 0, n_checks = 0, nmi_cnt, smi_cnt;
  wire logic [2:0] oe3 = {cpu_sleep_request_oe_o, system_mgmt_interrupt_req_oe_o, cpu_clock_stop_request_oe_o};
  cpu_sideband_nmi_control i_cpu_sideband_nmi_control (.*);
  cpu_host_model i_cpu_host_model (.clk_i(mclk_i), .nmi_i(nmi_o), .smi_oe_i(system_mgmt_interrupt_req_oe_o),
    .nmi_cnt_o(nmi_cnt), .smi_cnt_o(smi_cnt));
  // Free-running clock
  initial forever #4 mclk_i = ~mclk_i;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge mclk_i);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge mclk_i);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
  endtask
  // Reset values and an unmapped read
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    chk({nmi_o, oe3, irq_o}, 0);
    rchk(NMI_CTRL_OFS, 32'h0000_000C);
    rchk(NMI_MASK_OFS, 32'h0000_0080);
    rchk(PWR_CTRL_OFS, 0);
    rchk(IRQ_MASK_OFS, 0);
    rd(8'h14, d, r);
    chk({d, r}, RESP_SLVERR);
  endtask
  // System error through disable, mask and status; channel check through status and clear
  task automatic t_nmi();
    wr(IRQ_MASK_OFS, 32'h0000_0004);
    serr_n_i <= 0;
    cyc(6);
    chk(nmi_o, 0);
    wr(NMI_CTRL_OFS, 0);
    cyc(6);
    chk(nmi_o, 0);
    wr(NMI_MASK_OFS, 0);
    cyc(3);
    chk({nmi_o, irq_o}, 3);
    chk(nmi_cnt, 1);
    serr_n_i <= 1;
    cyc(6);
    rchk(NMI_CTRL_OFS, 32'h0000_0080);
    chk(nmi_o, 1);
    wr(NMI_CTRL_OFS, 32'h0000_0004);
    cyc(2);
    chk(nmi_o, 0);
    rchk(NMI_CTRL_OFS, 32'h0000_0004);
    rchk(IRQ_STAT_OFS, 32'h0000_0005);
    cyc(2);
    chk(irq_o, 0);
    chan_chk_n_i <= 0;
    cyc(6);
    chk(nmi_o, 1);
    chk(nmi_cnt, 2);
    chan_chk_n_i <= 1;
    cyc(4);
    wr(NMI_CTRL_OFS, 32'h0000_0044);
    cyc(2);
    chk(nmi_o, 0);
    rchk(IRQ_STAT_OFS, 32'h0000_0006);
  endtask
  // Sleep, SMI and clock-stop by software, hardware and suspend
  task automatic t_power();
    wr(PWR_CTRL_OFS, 32'h0000_0007);
    cyc(2);
    chk(oe3, 3'h7);
    chk(smi_cnt, 1);
    wr(PWR_CTRL_OFS, 32'h0000_0018);
    cyc(2);
    chk(oe3, 0);
    smi_hw_event_i <= 1;
    stop_hw_event_i <= 1;
    cyc(5);
    chk(oe3, 3'h3);
    chk({smi_cnt, irq_o}, 4);
    rchk(IRQ_STAT_OFS, 32'h0000_0018);
    suspend_i <= 1;
    cyc(6);
    chk({oe3, nmi_o}, 0);
  endtask
  task automatic stop_test();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    cyc(4);
    rstn_i <= 1;
    cyc(1);
    t_reset();
    t_nmi();
    t_power();
    stop_test();
  end
  // Watchdog
  initial begin
    cyc(5000);
    failures++;
    stop_test();
  end
endmodule
